// ### spcu_pkg.sv
// constants, field layouts and types shared by the serial port control block
package spcu_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_CTRL = 8'h98;
	localparam logic [7:0] OFF_DATA = 8'h9C;
	localparam logic [7:0] OFF_PWR  = 8'hA0;
	localparam logic [7:0] OFF_STAT = 8'hA4;
	localparam logic [7:0] OFF_ICLR = 8'hA8;
	localparam logic [7:0] OFF_IEN  = 8'hAC;
	// power control bit positions
	localparam int PWR_EAS = 6;
	localparam int PWR_DBL = 7;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic       PWR_RST  = 1'b0;
	localparam logic [2:0] IRQ_RST  = 3'h0;
	// interrupt event bit positions
	localparam int EV_TX = 0;
	localparam int EV_RX = 1;
	localparam int EV_FE = 2;
	localparam int NEV   = 3;
	// clock and timing counts
	localparam int         CLK_HZ  = 25000000;
	localparam logic [3:0] SMP_A   = 4'h7;
	localparam logic [3:0] SMP_B   = 4'h8;
	localparam logic [3:0] SMP_C   = 4'h9;
	localparam logic [2:0] M0_LAST = 3'h7;
	localparam logic [3:0] BITS8   = 4'hA;
	localparam logic [3:0] BITS9   = 4'hB;
	localparam logic [3:0] STOP8   = 4'h9;
	localparam logic [3:0] STOP9   = 4'hA;
	localparam logic [3:0] NINTH   = 4'h9;
	localparam logic [3:0] LAST_DB = 4'h8;

	typedef enum logic [1:0] {
		MODE_SHIFT  = 2'b00,
		MODE_UART8  = 2'b01,
		MODE_UART9F = 2'b10,
		MODE_UART9T = 2'b11
	} spcu_mode_e;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_M0   = 3'b010,
		TX_UART = 3'b100
	} spcu_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_M0   = 3'b010,
		RX_UART = 3'b100
	} spcu_rx_e;

	// control register layout, bit 7 first
	typedef struct packed {
		logic modeSelLow;
		logic modeSelHigh;
		logic mpEnable;
		logic rxEnable;
		logic txNinth;
		logic rxNinth;
		logic txFlag;
		logic rxFlag;
	} spcu_ctrl_s;
endpackage

// ### spcu_div.sv
// free counter with clear and terminal pulse, used for prescale and bit timing
`timescale 1ns/1ns
module spcu_div #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         en,
	input  wire logic         clr,
	output logic [W-1:0]      cnt,
	output logic              wrap
);
	logic [W-1:0] cnt_q;

	// terminal pulse when the counter rolls over
	assign cnt  = cnt_q;
	assign wrap = en && (cnt_q == {W{1'b1}});

	// count enables, clear restarts the phase
	always_ff @(posedge clk) begin
		if (sys_rst || clr) begin
			cnt_q <= '0;
		end else if (en) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule

// ### spcu_vote.sv
// two-of-three bit detector for the oversampled receive line
`timescale 1ns/1ns
module spcu_vote (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic bitIn,
	input  wire logic takeA,
	input  wire logic takeB,
	output logic      majority
);
	logic smpA_q;
	logic smpB_q;

	// third sample is the live line
	assign majority = (smpA_q & smpB_q) | (smpA_q & bitIn) | (smpB_q & bitIn);

	// hold the first two samples
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			smpA_q <= 1'b1;
			smpB_q <= 1'b1;
		end else begin
			if (takeA) smpA_q <= bitIn;
			if (takeB) smpB_q <= bitIn;
		end
	end
endmodule

// ### spcu_top.sv
// serial port control: four-mode uart with control register over ahb-lite
`timescale 1ns/1ns
module spcu_top (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        timerTick,
	input  wire logic [7:0]  givenAddr,
	input  wire logic [7:0]  broadcastAddr,
	input  wire logic [7:0]  addrMask,
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOe,
	output logic             txdOut,
	output logic             irq
);
	spcu_pkg::spcu_ctrl_s ctrl_q;
	spcu_pkg::spcu_ctrl_s ctrl_d;
	spcu_pkg::spcu_ctrl_s wrByte;
	spcu_pkg::spcu_mode_e mode;
	spcu_pkg::spcu_tx_e   txState_q;
	spcu_pkg::spcu_rx_e   rxState_q;
	logic        fe_q;
	logic        fe_d;
	logic        eas_q;
	logic        dbl_q;
	logic [7:0]  rxBuf_q;
	logic [2:0]  stat_q;
	logic [2:0]  ien_q;
	logic        dpValid_q;
	logic        dpWrite_q;
	logic        dpMapped_q;
	logic [7:0]  dpAddr_q;
	logic [31:0] hrdata_q;
	logic        rxdS1_q;
	logic        rxdS2_q;
	logic        rxdPrev_q;
	logic [10:0] txShift_q;
	logic [3:0]  txLeft_q;
	logic        m0Phase_q;
	logic [2:0]  m0Cnt_q;
	logic        m0Smp_q;
	logic [7:0]  rxShift_q;
	logic [3:0]  rxIdx_q;
	logic        rxNinthBit_q;
	logic        txd_q;
	logic        rxdOut_q;
	logic        rxdOe_q;
	logic        preWrap;
	logic        txBitEnd;
	logic [3:0]  rxCnt;
	logic        vote;
	// bus decode
	wire        addrPhase = hsel && htrans[1] && hready;
	wire        aMapped   = (haddr[31:8] == 24'h00_0000);
	wire [7:0]  aOff      = haddr[7:0];
	wire        dpWr      = dpValid_q && dpWrite_q && dpMapped_q;
	wire        wrCtrl    = dpWr && (dpAddr_q == spcu_pkg::OFF_CTRL);
	wire        wrData    = dpWr && (dpAddr_q == spcu_pkg::OFF_DATA);
	wire        wrPwr     = dpWr && (dpAddr_q == spcu_pkg::OFF_PWR);
	wire        wrIclr    = dpWr && (dpAddr_q == spcu_pkg::OFF_ICLR);
	wire        wrIen     = dpWr && (dpAddr_q == spcu_pkg::OFF_IEN);
	wire [7:0]  ctrlView  = {eas_q ? fe_q : ctrl_q.modeSelLow, ctrl_q[6:0]};
	wire [7:0]  pwrView   = {dbl_q, eas_q, 6'h00};
	wire [7:0]  rdByte    = !aMapped ? 8'h00 :
		(aOff == spcu_pkg::OFF_CTRL) ? ctrlView :
		(aOff == spcu_pkg::OFF_DATA) ? rxBuf_q :
		(aOff == spcu_pkg::OFF_PWR)  ? pwrView :
		(aOff == spcu_pkg::OFF_STAT) ? {5'h00, stat_q} :
		(aOff == spcu_pkg::OFF_IEN)  ? {5'h00, ien_q} : 8'h00;
	assign wrByte    = hwdata[7:0];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	// address phase capture, read data registered for the data phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dpValid_q  <= 1'b0;
			dpWrite_q  <= 1'b0;
			dpMapped_q <= 1'b0;
			dpAddr_q   <= 8'h00;
			hrdata_q   <= 32'h0000_0000;
		end else begin
			dpValid_q  <= addrPhase;
			dpWrite_q  <= hwrite;
			dpMapped_q <= aMapped;
			dpAddr_q   <= aOff;
			if (addrPhase && !hwrite) hrdata_q <= {24'h00_0000, rdByte};
		end
	end
	// operating mode and bit-rate ticks
	assign mode = spcu_pkg::spcu_mode_e'({ctrl_q.modeSelLow, ctrl_q.modeSelHigh});
	wire nine    = ctrl_q.modeSelLow;
	wire srcTick = (mode == spcu_pkg::MODE_UART9F) ? 1'b1 : timerTick;
	wire tick16  = dbl_q ? srcTick : preWrap;
	// prescaler halves the source tick, bit timer restarts at the buffer write
	spcu_div #(.W(1)) uPre (.clk(clk), .sys_rst(sys_rst), .en(srcTick), .clr(1'b0), .cnt(), .wrap(preWrap));
	spcu_div #(.W(4)) uTxDiv (.clk(clk), .sys_rst(sys_rst), .en(tick16 && txState_q == spcu_pkg::TX_UART),
		.clr(wrData), .cnt(), .wrap(txBitEnd));
	// input line synchroniser and edge history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxdS1_q   <= 1'b1;
			rxdS2_q   <= 1'b1;
			rxdPrev_q <= 1'b1;
		end else begin
			rxdS1_q   <= rxdIn;
			rxdS2_q   <= rxdS1_q;
			rxdPrev_q <= rxdS2_q;
		end
	end
	// shift mode engine: two clocks per bit, clock low then high
	wire m0Act    = (txState_q == spcu_pkg::TX_M0) || (rxState_q == spcu_pkg::RX_M0);
	wire m0BitEnd = m0Act && m0Phase_q;
	wire m0Last   = (m0Cnt_q == spcu_pkg::M0_LAST);
	always_ff @(posedge clk) begin
		if (sys_rst || !m0Act) begin
			m0Phase_q <= 1'b0;
			m0Cnt_q   <= 3'h0;
			m0Smp_q   <= 1'b1;
		end else begin
			m0Phase_q <= !m0Phase_q;
			if (m0Phase_q) m0Cnt_q <= m0Cnt_q + 3'h1;
			if (!m0Phase_q) m0Smp_q <= rxdS2_q;
		end
	end
	// transmitter
	wire tiSet = (txState_q == spcu_pkg::TX_UART && txBitEnd && txLeft_q == 4'h2) ||
		(txState_q == spcu_pkg::TX_M0 && m0BitEnd && m0Last);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txState_q <= spcu_pkg::TX_IDLE;
			txShift_q <= 11'h7FF;
			txLeft_q  <= 4'h0;
		end else if (wrData) begin
			if (mode == spcu_pkg::MODE_SHIFT) begin
				txState_q <= spcu_pkg::TX_M0;
				txShift_q <= {3'h7, hwdata[7:0]};
			end else begin
				txState_q <= spcu_pkg::TX_UART;
				txShift_q <= {1'b1, nine ? ctrl_q.txNinth : 1'b1, hwdata[7:0], 1'b0};
				txLeft_q  <= nine ? spcu_pkg::BITS9 : spcu_pkg::BITS8;
			end
		end else begin
			case (txState_q)
				spcu_pkg::TX_UART: begin
					if (txBitEnd) begin
						txShift_q <= {1'b1, txShift_q[10:1]};
						txLeft_q  <= txLeft_q - 4'h1;
						if (txLeft_q == 4'h1) txState_q <= spcu_pkg::TX_IDLE;
					end
				end
				spcu_pkg::TX_M0: begin
					if (m0BitEnd) begin
						txShift_q <= {1'b1, txShift_q[10:1]};
						if (m0Last) txState_q <= spcu_pkg::TX_IDLE;
					end
				end
				default: txState_q <= spcu_pkg::TX_IDLE;
			endcase
		end
	end
	// receiver sample timing and bit detector
	wire rxUart   = (rxState_q == spcu_pkg::RX_UART);
	wire rxStart  = (rxState_q == spcu_pkg::RX_IDLE) && (mode != spcu_pkg::MODE_SHIFT) &&
		ctrl_q.rxEnable && rxdPrev_q && !rxdS2_q;
	wire m0RxGo   = (rxState_q == spcu_pkg::RX_IDLE) && (mode == spcu_pkg::MODE_SHIFT) &&
		ctrl_q.rxEnable && !ctrl_q.rxFlag && (txState_q == spcu_pkg::TX_IDLE) && !wrData;
	wire rxTick   = tick16 && rxUart;
	wire voteDone = rxTick && (rxCnt == spcu_pkg::SMP_C);
	spcu_div #(.W(4)) uRxDiv (.clk(clk), .sys_rst(sys_rst), .en(rxTick), .clr(rxStart), .cnt(rxCnt), .wrap());
	spcu_vote uVote (.clk(clk), .sys_rst(sys_rst), .bitIn(rxdS2_q), .takeA(rxTick && rxCnt == spcu_pkg::SMP_A),
		.takeB(rxTick && rxCnt == spcu_pkg::SMP_B), .majority(vote));
	// frame completion, filtering and error detection
	wire       isStop    = rxIdx_q == (nine ? spcu_pkg::STOP9 : spcu_pkg::STOP8);
	wire       stopHit   = rxUart && ctrl_q.rxEnable && voteDone && isStop;
	wire       matchGiv  = ((rxShift_q ^ givenAddr) & addrMask) == 8'h00;
	wire       matchBc   = ((rxShift_q ^ broadcastAddr) & addrMask) == 8'h00;
	wire       addrMatch = matchGiv || matchBc;
	wire       accept    = (mode == spcu_pkg::MODE_UART8) ? (!ctrl_q.mpEnable || vote)
		: (!ctrl_q.mpEnable || (rxNinthBit_q && addrMatch));
	wire       m0Done    = (rxState_q == spcu_pkg::RX_M0) && m0BitEnd && m0Last;
	wire       riSet     = m0Done || (stopHit && accept);
	wire       feSet     = stopHit && !vote;
	wire       rb8Val    = nine ? rxNinthBit_q : vote;
	wire [7:0] rxByteM0  = {m0Smp_q, rxShift_q[7:1]};
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxState_q    <= spcu_pkg::RX_IDLE;
			rxIdx_q      <= 4'h0;
			rxShift_q    <= 8'h00;
			rxNinthBit_q <= 1'b0;
			rxBuf_q      <= 8'h00;
		end else begin
			if (riSet) rxBuf_q <= m0Done ? rxByteM0 : rxShift_q;
			case (rxState_q)
				spcu_pkg::RX_IDLE: begin
					if (m0RxGo) begin
						rxState_q <= spcu_pkg::RX_M0;
					end else if (rxStart) begin
						rxState_q <= spcu_pkg::RX_UART;
						rxIdx_q   <= 4'h0;
					end
				end
				spcu_pkg::RX_M0: begin
					if (m0BitEnd) rxShift_q <= rxByteM0;
					if (!ctrl_q.rxEnable || m0Done) rxState_q <= spcu_pkg::RX_IDLE;
				end
				spcu_pkg::RX_UART: begin
					if (!ctrl_q.rxEnable) begin
						rxState_q <= spcu_pkg::RX_IDLE;
					end else if (voteDone) begin
						rxIdx_q <= rxIdx_q + 4'h1;
						if ((rxIdx_q == 4'h0 && vote) || isStop) rxState_q <= spcu_pkg::RX_IDLE;
						if (rxIdx_q != 4'h0 && rxIdx_q <= spcu_pkg::LAST_DB) begin
							rxShift_q <= {vote, rxShift_q[7:1]};
						end
						if (nine && rxIdx_q == spcu_pkg::NINTH) rxNinthBit_q <= vote;
					end
				end
				default: rxState_q <= spcu_pkg::RX_IDLE;
			endcase
		end
	end
	// control register next value, hardware sets win over software writes
	always_comb begin
		ctrl_d = ctrl_q;
		fe_d   = fe_q;
		if (wrCtrl) begin
			ctrl_d = wrByte;
			if (eas_q) begin
				ctrl_d.modeSelLow = ctrl_q.modeSelLow;
				fe_d              = wrByte.modeSelLow;
			end
		end
		if (tiSet) ctrl_d.txFlag = 1'b1;
		if (riSet) begin
			ctrl_d.rxFlag = 1'b1;
			if (!m0Done) ctrl_d.rxNinth = rb8Val;
		end
		if (feSet) fe_d = 1'b1;
	end
	// software registers and interrupt state
	wire [2:0] events = {feSet, riSet, tiSet};
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= spcu_pkg::CTRL_RST;
			fe_q   <= 1'b0;
			eas_q  <= spcu_pkg::PWR_RST;
			dbl_q  <= spcu_pkg::PWR_RST;
			stat_q <= spcu_pkg::IRQ_RST;
			ien_q  <= spcu_pkg::IRQ_RST;
		end else begin
			ctrl_q <= ctrl_d;
			fe_q   <= fe_d;
			stat_q <= (stat_q & ~(wrIclr ? hwdata[2:0] : 3'h0)) | events;
			if (wrPwr) begin
				eas_q <= hwdata[spcu_pkg::PWR_EAS];
				dbl_q <= hwdata[spcu_pkg::PWR_DBL];
			end
			if (wrIen) ien_q <= hwdata[2:0];
		end
	end
	assign irq = |(stat_q & ien_q); // level while an enabled event is pending
	// pin drivers, registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txd_q    <= 1'b1;
			rxdOut_q <= 1'b1;
			rxdOe_q  <= 1'b0;
		end else begin
			txd_q    <= m0Act ? m0Phase_q : ((txState_q == spcu_pkg::TX_UART) ? txShift_q[0] : 1'b1);
			rxdOut_q <= txShift_q[0];
			rxdOe_q  <= (txState_q == spcu_pkg::TX_M0);
		end
	end
	assign txdOut = txd_q;
	assign rxdOut = rxdOut_q;
	assign rxdOe  = rxdOe_q;
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_fe_sticky: assert property (fe_q && !(wrCtrl && eas_q) |=> fe_q)
		else $error("framing error lost without write");
	chk_fe_any_sel: assert property (feSet |=> fe_q)
		else $error("framing error not set");
	chk_rx_gated: assert property (!ctrl_q.rxEnable && rxState_q == spcu_pkg::RX_IDLE
		|=> rxState_q == spcu_pkg::RX_IDLE)
		else $error("reception started while disabled");
	chk_mp_filter: assert property (riSet && nine && ctrl_q.mpEnable |-> rxNinthBit_q && addrMatch)
		else $error("unaddressed frame raised receive flag");
	chk_m1_stop: assert property (riSet && mode == spcu_pkg::MODE_UART8 && ctrl_q.mpEnable |-> vote)
		else $error("mode 1 flag without valid stop");
	chk_tx_kick: assert property (wrData |=> txState_q != spcu_pkg::TX_IDLE)
		else $error("data write did not start transmit");
	chk_ninth_tx: assert property (wrData && nine |=> txShift_q[9] == $past(ctrl_q.txNinth))
		else $error("ninth bit not loaded");
	chk_ti_hold: assert property (ctrl_q.txFlag && !wrCtrl |=> ctrl_q.txFlag)
		else $error("transmit flag cleared by hardware");
	chk_m0_rate: assert property (m0Act && $past(m0Act) |-> m0Phase_q != $past(m0Phase_q))
		else $error("shift clock not half oscillator");
	chk_m0_nomp: assert property (m0Done |=> ctrl_q.rxFlag)
		else $error("shift receive flag missing");
	cov_uart_rx: cover property (stopHit && accept);
	cov_fe: cover property (feSet);
	cov_m0_tx: cover property (txState_q == spcu_pkg::TX_M0 ##1 tiSet);
endmodule

// ### spcu_node.sv
// remote serial node: drives frames on the receive line, captures frames from the transmit line
`timescale 1ns/1ns
module spcu_node (
	input  wire logic clk,
	input  wire logic txdOut,
	output logic      rxdIn
);
	// line rests high between frames
	initial rxdIn = 1'b1;

	// one frame out: start 0, data lsb first, optional ninth, stop
	task automatic send(input logic [7:0] d, input logic ninth, input logic stop, input logic nine, input int per);
		logic [10:0] f;
		int          nb;
		f  = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
		nb = nine ? 11 : 10;
		for (int i = 0; i < nb; i++) begin
			rxdIn <= f[i];
			repeat (per) @(posedge clk);
		end
		rxdIn <= 1'b1;
		@(posedge clk);
	endtask

	// one frame in, sampled mid bit: f[7:0] data, f[8] ninth or stop, f[9] stop
	task automatic recv(input logic nine, input int per, output logic [9:0] f);
		int n;
		f = 10'h3FF;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (txdOut !== 1'b0 && n < 4000);
		// no start bit seen: hand back unknowns so the caller counts a mismatch
		if (txdOut !== 1'b0) begin
			f = 'x;
			return;
		end
		repeat (per / 2) @(negedge clk);
		for (int i = 0; i < (nine ? 10 : 9); i++) begin
			repeat (per) @(negedge clk);
			f[i] = txdOut;
		end
		@(posedge clk);
	endtask
endmodule

// ### spcu_top_test.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ns
module spcu_top_test;
	logic        clk;
	logic        sys_rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        timerTick;
	logic        rxdIn;
	logic        rxdOut;
	logic        rxdOe;
	logic        txdOut;
	logic        irq;
	logic [9:0]  frame;
	logic [31:0] rd;
	logic [7:0]  sh;
	logic [7:0]  givenAddr;
	logic [7:0]  broadcastAddr;
	logic [7:0]  addrMask;
	int          num_errors;
	int          samples_checked;

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	spcu_top dut (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.hsel          (hsel),
		.haddr         (haddr),
		.htrans        (htrans),
		.hwrite        (hwrite),
		.hsize         (hsize),
		.hwdata        (hwdata),
		.hready        (hready),
		.hreadyout     (hreadyout),
		.hresp         (hresp),
		.hrdata        (hrdata),
		.timerTick     (timerTick),
		.givenAddr     (givenAddr),
		.broadcastAddr (broadcastAddr),
		.addrMask      (addrMask),
		.rxdIn         (rxdIn),
		.rxdOut        (rxdOut),
		.rxdOe         (rxdOe),
		.txdOut        (txdOut),
		.irq           (irq)
	);

	spcu_node node (
		.clk    (clk),
		.txdOut (txdOut),
		.rxdIn  (rxdIn)
	);

	// 25 MHz clock and a timer pulse every second cycle
	initial clk = 1'b0;
	always #20 clk = ~clk;
	always @(posedge clk) timerTick <= ~timerTick;

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// bounded wait for ready sampled high at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask

	// one single-word transfer: address phase, then data phase
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, {24'h00_0000, d}, rd);
	endtask

	// read and compare the bits under mask; upper bits must read zero
	task automatic rcm(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		xfer(a, 1'b0, 32'h0000_0000, rd);
		check(nm, rd & {24'hFF_FFFF, m}, {24'h00_0000, e & m});
	endtask

	task automatic irq_is(input logic e);
		@(negedge clk);
		check("irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
		@(posedge clk);
	endtask

	// send a byte and capture the frame on the transmit line
	task automatic txcase(input logic [7:0] pwr, input logic [7:0] ctrl, input logic [7:0] d, input int per,
			input logic nine);
		wr(spcu_pkg::OFF_PWR, pwr);
		wr(spcu_pkg::OFF_CTRL, ctrl);
		wr(spcu_pkg::OFF_ICLR, 8'h07);
		wr(spcu_pkg::OFF_DATA, d);
		node.recv(nine, per, frame);
		check("tx frame", {22'h00_0000, frame}, {22'h00_0000, 1'b1, nine ? ctrl[3] : 1'b1, d});
		rcm("tx flag", spcu_pkg::OFF_CTRL, 8'hFF, ctrl | 8'h02);
		rcm("tx status", spcu_pkg::OFF_STAT, 8'h01, 8'h01);
	endtask

	// far node sends a frame; control bits and status are compared, the buffer only when a receive flag is expected
	task automatic rxcase(input logic [7:0] ctrl, input logic [7:0] pwr, input int per, input logic nine,
			input logic ninth, input logic stop, input logic [7:0] d, input logic [7:0] m, input logic [7:0] e);
		wr(spcu_pkg::OFF_CTRL, ctrl);
		wr(spcu_pkg::OFF_PWR, pwr);
		wr(spcu_pkg::OFF_ICLR, 8'h07);
		node.send(d, ninth, stop, nine, per);
		rcm("rx ctrl", spcu_pkg::OFF_CTRL, m, e);
		rcm("rx status", spcu_pkg::OFF_STAT, 8'h02, {6'h00, e[0], 1'b0});
		if (e[0]) rcm("rx data", spcu_pkg::OFF_DATA, 8'hFF, d);
	endtask

	// main sequence
	initial begin
		int n;
		sys_rst   = 1'b1;
		hsel      = 1'b0;
		haddr     = 32'h0000_0000;
		htrans    = 2'b00;
		hwrite    = 1'b0;
		hsize     = 3'b010;
		hwdata    = 32'h0000_0000;
		timerTick = 1'b0;
		givenAddr     = 8'h42;
		broadcastAddr = 8'hFF;
		addrMask      = 8'hFF;
		num_errors      = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rcm("ctrl reset", spcu_pkg::OFF_CTRL, 8'hFF, 8'h00);
		check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
		rcm("pwr reset", spcu_pkg::OFF_PWR, 8'hFF, 8'h00);
		rcm("stat reset", spcu_pkg::OFF_STAT, 8'hFF, 8'h00);
		rcm("unmapped", 8'h50, 8'hFF, 8'h00);
		wr(spcu_pkg::OFF_IEN, 8'h07);
		rcm("ien", spcu_pkg::OFF_IEN, 8'hFF, 8'h07);
		rcm("iclr", spcu_pkg::OFF_ICLR, 8'hFF, 8'h00);
		$display("test registers done");
		txcase(8'h80, 8'h40, 8'h35, 32, 1'b0);
		txcase(8'h80, 8'h88, 8'hA5, 16, 1'b1);
		txcase(8'h00, 8'h80, 8'h5A, 32, 1'b1);
		txcase(8'h00, 8'hC8, 8'hC3, 64, 1'b1);
		irq_is(1'b1);
		wr(spcu_pkg::OFF_IEN, 8'h00);
		irq_is(1'b0);
		wr(spcu_pkg::OFF_IEN, 8'h07);
		irq_is(1'b1);
		wr(spcu_pkg::OFF_ICLR, 8'h07);
		irq_is(1'b0);
		$display("test transmit done");
		rxcase(8'h90, 8'h80, 16, 1'b1, 1'b0, 1'b1, 8'h3C, 8'hFF, 8'h91);
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b0, 1'b1, 8'h42, 8'h01, 8'h00);
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b1, 1'b1, 8'h42, 8'hFF, 8'hB5);
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'hB5);
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b1, 1'b1, 8'h43, 8'h01, 8'h00);
		addrMask <= 8'hF0;
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b1, 1'b1, 8'h4E, 8'hFF, 8'hB5);
		rxcase(8'hB0, 8'h80, 16, 1'b1, 1'b1, 1'b1, 8'h52, 8'h01, 8'h00);
		addrMask <= 8'hFF;
		rxcase(8'h80, 8'h80, 16, 1'b1, 1'b0, 1'b1, 8'h11, 8'h01, 8'h00);
		rxcase(8'h50, 8'h80, 32, 1'b0, 1'b0, 1'b1, 8'hC3, 8'hFF, 8'h55);
		rxcase(8'h70, 8'h80, 32, 1'b0, 1'b0, 1'b0, 8'h5A, 8'h81, 8'h00);
		rcm("fe status", spcu_pkg::OFF_STAT, 8'h04, 8'h04);
		rxcase(8'h50, 8'hC0, 32, 1'b0, 1'b0, 1'b1, 8'hE7, 8'hFF, 8'hD5);
		wr(spcu_pkg::OFF_CTRL, 8'h50);
		rcm("fe clear", spcu_pkg::OFF_CTRL, 8'h80, 8'h00);
		$display("test receive done");
		wr(spcu_pkg::OFF_PWR, 8'h00);
		wr(spcu_pkg::OFF_CTRL, 8'h00);
		wr(spcu_pkg::OFF_DATA, 8'h96);
		sh = 8'h00;
		for (int i = 0; i < 8; i++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (txdOut !== 1'b0 && n < 99);
			do begin
				@(negedge clk);
				n++;
			end while (txdOut !== 1'b1 && n < 99);
			if (n >= 99) begin
				num_errors++;
				stop_test();
			end
			sh[i] = rxdOut;
			if (i == 0) check("shift oe", {31'h0000_0000, rxdOe}, 32'h0000_0001);
		end
		@(posedge clk);
		check("shift data", {24'h00_0000, sh}, {24'h00_0000, 8'h96});
		rcm("shift tx flag", spcu_pkg::OFF_CTRL, 8'h02, 8'h02);
		check("shift oe off", {31'h0000_0000, rxdOe}, 32'h0000_0000);
		wr(spcu_pkg::OFF_CTRL, 8'h30);
		repeat (40) @(posedge clk);
		rcm("shift rx flag", spcu_pkg::OFF_CTRL, 8'h01, 8'h01);
		rcm("shift rx data", spcu_pkg::OFF_DATA, 8'hFF, 8'hFF);
		$display("test shift mode done");
		stop_test();
	end

	// overall limit on run length
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule
